// ---- asp_pkg.sv ----
// Package of constants and types for the angle sensor serial slave.
//
// Contract
// - Configured operating mode starts only after chip select first goes high; code starts it on the first clock after reset.
// - Mode 0 and mode 3 both accepted, detected from clock idle level.
// - Command bits sampled on rising clock edge, response shifted on falling edge.
// - Words travel most significant bit first in both directions.
// - Output buffer loads a fresh angle every 1 us unless frozen.
// - Chip select fall freezes output buffer; chip select rise releases it.
// - Angle read: 16 clocks, zero command in, angle bits 15..0 out.
// - Early ended read still delivers the upper angle bits sent so far.
// - Faster reads return the same angle until a new sample loads.
// - Register read second frame: register byte high, angle byte low.
// - Register write second frame: stored value high, angle byte low.
// - Register 9 bit 7 set makes angle increase counterclockwise.
// - Field high and low flags appear at register 27 bits 7 and 6.
// - Command codes 000,001,010,100,101,110,111; memory commands return the 16-bit angle.
// - Store and restore ignored while memory busy; busy shown as high pin.
package asp_pkg;
   localparam int unsigned FRAME_BITS     = 16;
   localparam int unsigned CLK_SYS_MHZ    = 100;
   localparam int unsigned REFRESH_NS     = 1000;
   localparam int unsigned REFRESH_CYCLES = REFRESH_NS * CLK_SYS_MHZ / 1000;
   localparam logic [2:0] CMD_READ_ANGLE  = 3'h0;
   localparam logic [2:0] CMD_CLEAR_ERR   = 3'h1;
   localparam logic [2:0] CMD_READ_REG    = 3'h2;
   localparam logic [2:0] CMD_WRITE_REG   = 3'h4;
   localparam logic [2:0] CMD_RESTORE_ALL = 3'h5;
   localparam logic [2:0] CMD_STORE_ALL   = 3'h6;
   localparam logic [2:0] CMD_STORE_ONE   = 3'h7;
   localparam logic [4:0] REG_DIRECTION   = 5'h09;
   localparam logic [4:0] REG_ERRORS      = 5'h1A;
   localparam logic [4:0] REG_FIELD       = 5'h1B;
   localparam int unsigned DIR_BIT        = 7;
   localparam int unsigned FIELD_HIGH_BIT = 7;
   localparam int unsigned FIELD_LOW_BIT  = 6;
   localparam logic [7:0] ERR_MASK        = 8'h0E;
   localparam int unsigned NUM_REGS       = 32;
   typedef enum logic [1:0] {
      ASP_IDLE  = 2'b00,
      ASP_FRAME = 2'b01,
      ASP_DONE  = 2'b11
   } asp_frame_e;
endpackage : asp_pkg

// ---- asp_sync.sv ----
// Two flip-flop level synchroniser.
`timescale 1ns/100ps
`default_nettype none
module asp_sync
   import asp_pkg::*;
#(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic d_in,
   output logic      q_out
);
   logic meta;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta  <= RESET_VAL;
         q_out <= RESET_VAL;
      end else begin
         meta  <= d_in;
         q_out <= meta;
      end
   end
endmodule : asp_sync
`default_nettype wire

// ---- asp_shifter.sv ----
// Serial clock domain shifter: command capture and response shifting.
`timescale 1ns/100ps
`default_nettype none
module asp_shifter
   import asp_pkg::*;
(
   input  wire logic        sclk_in,
   input  wire logic        rst_in,
   input  wire logic        cs_n_in,
   input  wire logic        mosi_in,
   input  wire logic [15:0] tx_word_in,
   output logic [15:0]      rx_word_out,
   output logic             rx_toggle_out,
   output logic             miso_out,
   output logic             miso_oe_out
);
   logic [4:0]  bit_cnt;
   logic [15:0] rx_shift;
   logic [15:0] tx_shift;
   logic        primed;
   wire  [15:0] next_rx = {rx_shift[14:0], mosi_in};

   // Chip select acts as the async clear so no sclk edge is needed outside a frame.
   always_ff @(posedge sclk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         bit_cnt  <= 5'h00;
         rx_shift <= 16'h0000;
      end else begin
         rx_shift <= next_rx;
         bit_cnt  <= bit_cnt + 5'h01;
      end
   end

   // Word handed over only on the sixteenth rising edge, so short frames are dropped.
   // The system reset gives the toggle a known level before the crossing reads it.
   always_ff @(posedge sclk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_word_out   <= 16'h0000;
         rx_toggle_out <= 1'b0;
      end else if (!cs_n_in && bit_cnt == 5'(FRAME_BITS - 1)) begin
         rx_word_out   <= next_rx;
         rx_toggle_out <= ~rx_toggle_out;
      end
   end

   // Falling edges shift. Mode 3 meets its first falling edge before any rise and loads
   // the whole word; mode 0 meets it after the first rise, when the MSB is already sent.
   always_ff @(negedge sclk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         tx_shift <= 16'h0000;
         primed   <= 1'b0;
      end else if (!primed) begin
         tx_shift <= (bit_cnt == 5'h00) ? tx_word_in : {tx_word_in[14:0], 1'b0};
         primed   <= 1'b1;
      end else begin
         tx_shift <= {tx_shift[14:0], 1'b0};
      end
   end

   // Before any falling edge the MSB of the frozen word is presented directly.
   assign miso_out    = primed ? tx_shift[15] : tx_word_in[15];
   assign miso_oe_out = ~cs_n_in;
endmodule : asp_shifter
`default_nettype wire

// ---- asp_top.sv ----
// Top of the angle sensor serial slave: registers, commands and output buffer.
`timescale 1ns/100ps
`default_nettype none
module asp_top
   import asp_pkg::*;
#(
   parameter int unsigned REFRESH_CNT = REFRESH_CYCLES
) (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   input  wire logic        sclk_in,
   input  wire logic        cs_n_in,
   input  wire logic        mosi_in,
   input  wire logic [15:0] angle_raw_in,
   input  wire logic        field_high_flag_in,
   input  wire logic        field_low_flag_in,
   input  wire logic [7:0]  error_flags_in,
   input  wire logic        nvm_done_in,
   output logic             miso_out,
   output logic             miso_oe_out,
   output logic             nvm_busy_out,
   output logic             mode_run_out,
   output logic             direction_ccw_out,
   output logic [2:0]       nvm_cmd_out,
   output logic [4:0]       nvm_addr_out,
   output logic             nvm_start_out
);
   ////////////////////////////////////////////////////////////////////////////////
   // Crossings from the link.
   logic        cs_n_sync;
   logic        cs_n_prev;
   logic        rx_toggle;
   logic        rx_toggle_s;
   logic        rx_toggle_prev;
   logic [15:0] rx_word;
   logic [15:0] tx_word;
   logic [15:0] out_buf;
   logic [15:0] resp_word;
   logic        resp_valid;
   logic [7:0]  regs [NUM_REGS];
   logic [7:0]  err_flags;
   logic [$clog2(REFRESH_CNT+1)-1:0] refresh_cnt;
   asp_frame_e  frame_state;

   asp_sync #(.RESET_VAL(1'b1)) u_cs_sync (
      .clk_in (clk_sys_in),
      .rst_in (rst_in),
      .d_in   (cs_n_in),
      .q_out  (cs_n_sync)
   );
   asp_sync #(.RESET_VAL(1'b0)) u_tog_sync (
      .clk_in (clk_sys_in),
      .rst_in (rst_in),
      .d_in   (rx_toggle),
      .q_out  (rx_toggle_s)
   );

   asp_shifter u_shift (
      .sclk_in       (sclk_in),
      .rst_in        (rst_in),
      .cs_n_in       (cs_n_in),
      .mosi_in       (mosi_in),
      .tx_word_in    (tx_word),
      .rx_word_out   (rx_word),
      .rx_toggle_out (rx_toggle),
      .miso_out      (miso_out),
      .miso_oe_out   (miso_oe_out)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Decodes and frame edges.
   wire cs_fall   = cs_n_prev & ~cs_n_sync;
   wire cs_rise   = ~cs_n_prev & cs_n_sync;
   wire word_done = rx_toggle_s ^ rx_toggle_prev;
   // rx_word is stable: it changed on the same sclk edge as the toggle, which reaches here through two flip-flops.
   wire [2:0] cmd_code = rx_word[15:13];
   wire [4:0] cmd_addr = rx_word[12:8];
   wire [7:0] cmd_data = rx_word[7:0];
   wire frozen     = ~cs_n_sync;
   wire refresh_now = (refresh_cnt == '0) && !frozen;
   wire is_nvm_cmd = (cmd_code == CMD_RESTORE_ALL) || (cmd_code == CMD_STORE_ALL)
                   || (cmd_code == CMD_STORE_ONE);

   // Register view with live flags folded in.
   function automatic logic [7:0] reg_view(input logic [4:0] a);
      logic [7:0] v;
      v = regs[a];
      if (a == REG_ERRORS) v = err_flags & ERR_MASK;
      if (a == REG_FIELD) begin
         v = 8'h00;
         v[FIELD_HIGH_BIT] = field_high_flag_in;
         v[FIELD_LOW_BIT]  = field_low_flag_in;
      end
      return v;
   endfunction : reg_view

   // The reply's low byte is the angle frozen for this very frame, not a stale one.
   assign tx_word = resp_valid ? {resp_word[15:8], out_buf[15:8]} : out_buf;
   assign direction_ccw_out = regs[REG_DIRECTION][DIR_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // Edge history and start-up mode gate.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         cs_n_prev      <= 1'b1;
         rx_toggle_prev <= 1'b0;
         mode_run_out   <= 1'b0;
      end else begin
         cs_n_prev      <= cs_n_sync;
         rx_toggle_prev <= rx_toggle_s;
         if (cs_n_sync) mode_run_out <= 1'b1;
      end
   end

   // Frame tracking state.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         frame_state <= ASP_IDLE;
      end else begin
         case (frame_state)
            ASP_IDLE:  if (cs_fall) frame_state <= ASP_FRAME;
            ASP_FRAME: if (word_done) frame_state <= ASP_DONE;
                       else if (cs_rise) frame_state <= ASP_IDLE;
            ASP_DONE:  if (cs_rise) frame_state <= ASP_IDLE;
            default:   frame_state <= ASP_IDLE;
         endcase
      end
   end

   // Angle refresh; the buffer holds still while chip select is low.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         refresh_cnt <= '0;
         out_buf     <= 16'h0000;
      end else begin
         if (refresh_now) begin
            refresh_cnt <= ($clog2(REFRESH_CNT+1))'(REFRESH_CNT - 1);
            out_buf     <= direction_ccw_out ? (16'h0000 - angle_raw_in) : angle_raw_in;
         end else if (refresh_cnt != '0) begin
            refresh_cnt <= refresh_cnt - 1'b1;
         end
      end
   end

   // Second-frame reply: prepared after a full command, kept for later frames until the next full word ends.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         resp_valid <= 1'b0;
         resp_word  <= 16'h0000;
      end else if (word_done) begin
         if (cmd_code == CMD_READ_REG) begin
            resp_valid <= 1'b1;
            resp_word  <= {reg_view(cmd_addr), 8'h00};
         end else if (cmd_code == CMD_WRITE_REG) begin
            resp_valid <= 1'b1;
            resp_word  <= {cmd_data, 8'h00};
         end else begin
            resp_valid <= 1'b0;
         end
      end else if (cs_rise && frame_state == ASP_IDLE) begin
         resp_valid <= resp_valid;
      end else if (cs_rise && frame_state == ASP_DONE && !resp_valid) begin
         resp_valid <= 1'b0;
      end else if (cs_rise && frame_state == ASP_FRAME) begin
         resp_valid <= resp_valid;
      end
   end

   // Register writes and error flags; a hardware error wins over a clear.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < NUM_REGS; i++) regs[i] <= 8'h00;
         err_flags <= 8'h00;
      end else begin
         if (word_done && cmd_code == CMD_WRITE_REG) regs[cmd_addr] <= cmd_data;
         if (word_done && cmd_code == CMD_CLEAR_ERR) err_flags <= error_flags_in & ERR_MASK;
         else err_flags <= err_flags | (error_flags_in & ERR_MASK);
      end
   end

   // Memory command launch; commands arriving while busy are dropped.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         nvm_busy_out  <= 1'b0;
         nvm_start_out <= 1'b0;
         nvm_cmd_out   <= 3'h0;
         nvm_addr_out  <= 5'h00;
      end else begin
         nvm_start_out <= 1'b0;
         if (word_done && is_nvm_cmd && !nvm_busy_out) begin
            nvm_busy_out  <= 1'b1;
            nvm_start_out <= 1'b1;
            nvm_cmd_out   <= cmd_code;
            nvm_addr_out  <= cmd_addr;
         end else if (nvm_done_in) begin
            nvm_busy_out  <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   chk_buf_frozen: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      frozen && $past(frozen) |-> $stable(out_buf))
      else $error("output buffer changed while frozen");
   chk_refresh_rate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      refresh_now |=> !refresh_now [*2])
      else $error("refresh came too soon");
   chk_busy_ignore: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      nvm_busy_out && !nvm_done_in |=> !nvm_start_out)
      else $error("memory command launched while busy");
   chk_busy_start: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      nvm_start_out |-> nvm_busy_out)
      else $error("start without busy");
   chk_write_store: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      word_done && cmd_code == CMD_WRITE_REG |=> regs[$past(cmd_addr)] == $past(cmd_data))
      else $error("register write lost");
   chk_write_ack: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      word_done && cmd_code == CMD_WRITE_REG |=> resp_word[15:8] == $past(cmd_data))
      else $error("write acknowledge wrong");
   chk_mode_start: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      mode_run_out && !$past(mode_run_out) |-> $past(cs_n_sync))
      else $error("mode started without chip select high");
   chk_miso_drive: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      cs_n_in |-> !miso_oe_out)
      else $error("data out driven while deselected");
   chk_dir_bit: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      direction_ccw_out == regs[REG_DIRECTION][DIR_BIT])
      else $error("direction bit mismatch");

   ////////////////////////////////////////////////////////////////////////////////
   // Named steps of a command, shared by the checks below.
   sequence s_nvm_word;
      word_done && is_nvm_cmd && !nvm_busy_out;
   endsequence
   sequence s_nvm_launch;
      nvm_start_out && nvm_busy_out;
   endsequence
   sequence s_reg_read;
      word_done && cmd_code == CMD_READ_REG;
   endsequence
   sequence s_reply_armed;
      resp_valid;
   endsequence

   // A memory command seen while idle launches exactly once, with its code and address.
   chk_nvm_launch: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      s_nvm_word |=> s_nvm_launch)
      else $error("memory command not launched");

   chk_nvm_code: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      s_nvm_word |=> nvm_cmd_out == $past(cmd_code) && nvm_addr_out == $past(cmd_addr))
      else $error("memory command code or address wrong");

   chk_start_pulse: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      nvm_start_out |=> !nvm_start_out)
      else $error("launch pulse longer than one cycle");

   // Register commands arm a reply for the next frame; other commands clear it.
   chk_read_reply: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      s_reg_read |=> s_reply_armed)
      else $error("read reply not armed");

   chk_write_reply: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      word_done && cmd_code == CMD_WRITE_REG |=> resp_valid)
      else $error("write reply not armed");

   chk_read_field: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      s_reg_read && cmd_addr == REG_FIELD |=>
         resp_word[15:8] == {$past(field_high_flag_in), $past(field_low_flag_in), 6'h00})
      else $error("field flags reply wrong");

   chk_plain_reply: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      word_done && cmd_code != CMD_READ_REG && cmd_code != CMD_WRITE_REG |=> !resp_valid)
      else $error("angle frame carries a register reply");

   // Error flags stay until cleared, and a clear with no new error empties them.
   chk_clear_err: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      word_done && cmd_code == CMD_CLEAR_ERR && error_flags_in == 8'h00 |=> err_flags == 8'h00)
      else $error("error flags not cleared");

   chk_err_sticky: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      err_flags != 8'h00 && !(word_done && cmd_code == CMD_CLEAR_ERR) |=> err_flags != 8'h00)
      else $error("error flags lost without a clear");

   // Once started the configured mode keeps running.
   chk_mode_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      mode_run_out |=> mode_run_out)
      else $error("operating mode stopped");

   // Frame tracking follows chip select and the handed-over word.
   chk_frame_start: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      frame_state == ASP_IDLE && cs_fall |=> frame_state == ASP_FRAME)
      else $error("frame start missed");

   chk_frame_done: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      frame_state == ASP_FRAME && word_done |=> frame_state == ASP_DONE)
      else $error("full word not recorded");

   chk_idle_release: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      cs_rise && !word_done |=> frame_state == ASP_IDLE)
      else $error("frame end missed");

endmodule : asp_top
`default_nettype wire

// ---- asp_master_model.sv ----
// Serial master model that drives frames into the angle sensor slave.
`timescale 1ns/100ps
`default_nettype none
module asp_master_model (
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      mosi_out,
   input  wire logic miso_in
);
   // Idle levels at start; outside frames the link clock only moves to its idle level.
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      mosi_out = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   // One frame of nbits clocks at 12.5 MHz; the idle gap comes first so the next frame
   // always honours the minimum chip select high time, whoever called before.
   task automatic xfer(input logic m3, input logic [15:0] cmd, input int nbits,
                       output logic [15:0] resp);
      resp = 16'h0000;
      sclk_out = m3;
      #200 cs_n_out = 1'b0;
      #160;
      for (int i = 15; i > 15 - nbits; i--) begin
         sclk_out = 1'b0;
         mosi_out = cmd[i];
         #40 sclk_out = 1'b1;
         resp[i] = miso_in;
         #40;
      end
      cs_n_out = 1'b1;
      sclk_out = m3;
      mosi_out = ~mosi_out; // Released line shows no stale value.
   endtask : xfer
endmodule : asp_master_model
`default_nettype wire

// ---- angle_sensor_spi_slave_test.sv ----
// Self-checking bench for the angle sensor serial slave.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
   $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
module angle_sensor_spi_slave_test import asp_pkg::*;;
   logic        clk_sys_in, rst_in, sclk, cs_n, mosi, miso, miso_oe, nvm_done;
   logic        field_high, field_low, busy, run, ccw, start;
   logic [15:0] angle, resp;
   logic [7:0]  err_flags;
   logic [2:0]  nvm_cmd;
   logic [4:0]  nvm_addr;
   int          failures, n_compared, n_start;
   wire         miso_line = miso_oe ? miso : 1'bz;

   asp_master_model MST (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso_line));
   asp_top #(.REFRESH_CNT(4)) DUT (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .sclk_in(sclk), .cs_n_in(cs_n),
      .mosi_in(mosi), .angle_raw_in(angle), .field_high_flag_in(field_high),
      .field_low_flag_in(field_low), .error_flags_in(err_flags), .nvm_done_in(nvm_done),
      .miso_out(miso), .miso_oe_out(miso_oe), .nvm_busy_out(busy), .mode_run_out(run),
      .direction_ccw_out(ccw), .nvm_cmd_out(nvm_cmd), .nvm_addr_out(nvm_addr),
      .nvm_start_out(start));
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Clock and a watchdog; a hang counts as a mismatch.
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      #300000 failures++;
      summarize();
   end
   // Launch pulses are counted so that dropped commands show.
   always @(posedge clk_sys_in) if (start === 1'b1) n_start++;
   task automatic summarize();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize
   task automatic set_angle(input logic [15:0] v);
      @(negedge clk_sys_in) angle <= v;
   endtask : set_angle
   // A register command frame followed by the frame that carries its answer.
   task automatic reg_op(input logic [2:0] op, input logic [4:0] a, input logic [7:0] d);
      MST.xfer(1'b0, {op, a, d}, 16, resp);
      MST.xfer(1'b0, 16'h0000, 16, resp);
   endtask : reg_op
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Full reads in both clock modes, then an early ended read.
   task automatic t_angle();
      set_angle(16'hA5C3);
      for (int m = 0; m < 2; m++) begin
         MST.xfer(m[0], 16'h0000, 16, resp);
         `CHK(resp, 16'hA5C3)
      end
      MST.xfer(1'b0, 16'h0000, 8, resp);
      `CHK(resp[15:8], 8'hA5)
   endtask : t_angle
   // Angle moves mid-frame: the frame keeps the old value, the next one sees the new.
   task automatic t_freeze();
      set_angle(16'h1234);
      fork
         MST.xfer(1'b0, 16'h0000, 16, resp);
         begin
            #800 set_angle(16'h4321);
         end
      join
      `CHK(resp, 16'h1234)
      MST.xfer(1'b0, 16'h0000, 16, resp);
      `CHK(resp, 16'h4321)
   endtask : t_freeze
   // Direction write, readback, a cut short write that must not land, then undo.
   task automatic t_write();
      set_angle(16'h0100);
      MST.xfer(1'b1, {CMD_WRITE_REG, REG_DIRECTION, 8'h80}, 16, resp);
      MST.xfer(1'b1, 16'h0000, 16, resp);
      `CHK(resp, 16'h80FF)
      `CHK(ccw, 1'b1)
      MST.xfer(1'b0, 16'h0000, 16, resp);
      `CHK(resp, 16'hFF00)
      reg_op(CMD_READ_REG, REG_DIRECTION, 8'h00);
      `CHK(resp, 16'h80FF)
      MST.xfer(1'b0, {CMD_WRITE_REG, REG_DIRECTION, 8'h00}, 10, resp);
      reg_op(CMD_READ_REG, REG_DIRECTION, 8'h00);
      `CHK(resp[15:8], 8'h80)
      reg_op(CMD_WRITE_REG, REG_DIRECTION, 8'h00);
      `CHK(resp[15:8], 8'h00)
      `CHK(ccw, 1'b0)
   endtask : t_write
   // Field flags and sticky error flags with their clear command.
   task automatic t_flags();
      @(negedge clk_sys_in) field_high <= 1'b1;
      reg_op(CMD_READ_REG, REG_FIELD, 8'h00);
      `CHK(resp[15:8], 8'h80)
      @(negedge clk_sys_in) {field_high, field_low, err_flags} <= {2'b01, 8'h02};
      @(negedge clk_sys_in) err_flags <= 8'h00;
      reg_op(CMD_READ_REG, REG_FIELD, 8'h00);
      `CHK(resp[15:8], 8'h40)
      reg_op(CMD_READ_REG, REG_ERRORS, 8'h00);
      `CHK(resp[15:8], 8'h02)
      MST.xfer(1'b0, {CMD_CLEAR_ERR, 13'h0000}, 16, resp);
      `CHK(resp, 16'h0100)
      reg_op(CMD_READ_REG, REG_ERRORS, 8'h00);
      `CHK(resp[15:8], 8'h00)
   endtask : t_flags
   // Each memory command launches once; a second one while busy is dropped.
   task automatic t_nvm();
      logic [2:0] codes [3];
      int         s0;
      codes = '{CMD_STORE_ONE, CMD_STORE_ALL, CMD_RESTORE_ALL};
      foreach (codes[k]) begin
         s0 = n_start;
         MST.xfer(1'b0, {codes[k], 5'h03, 8'h00}, 16, resp);
         `CHK(resp, 16'h0100)
         repeat (10) @(negedge clk_sys_in);
         `CHK(n_start - s0, 1)
         `CHK(nvm_cmd, codes[k])
         if (k == 0) `CHK(nvm_addr, 5'h03)
         `CHK(busy, 1'b1)
         MST.xfer(1'b0, {CMD_STORE_ALL, 13'h0000}, 16, resp);
         repeat (10) @(negedge clk_sys_in);
         `CHK(n_start - s0, 1)
         nvm_done <= 1'b1;
         @(negedge clk_sys_in) nvm_done <= 1'b0;
         for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk_sys_in);
         `CHK(busy, 1'b0)
      end
   endtask : t_nvm
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset, then every scenario in turn.
   initial begin
      {rst_in, angle, field_high, field_low, err_flags, nvm_done} = {1'b1, 28'h0};
      failures = 0;
      n_compared = 0;
      n_start = 0;
      repeat (4) @(posedge clk_sys_in);
      @(negedge clk_sys_in) rst_in <= 1'b0;
      repeat (6) @(negedge clk_sys_in);
      `CHK(run, 1'b1)
      `CHK(miso_oe, 1'b0)
      t_angle();
      t_freeze();
      t_write();
      t_flags();
      t_nvm();
      summarize();
   end
endmodule : angle_sensor_spi_slave_test
`default_nettype wire
